// [rtl/uart_shadow_data_port.v]
// UART shadow data port: AHB-Lite slave giving the receive and transmit
// byte path, holding registers for FIFO-off mode and FIFOs for FIFO-on.
// Beside the sixteen alias words it keeps its own control, status,
// interrupt status and interrupt mask registers.
// Assumes an external deserialiser strobing received bytes and an external
// serialiser that takes one byte whenever it signals ready.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`include "uart_shadow_regs.vh"

module uart_shadow_data_port #(
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW = `FIFO_ADDR_BITS
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata_r,
    output reg hreadyout_r,
    output reg hresp_r,
    // Receive side from the deserialisers
    input wire rxStrobe,
    input wire [7:0] rxSerialByte,
    input wire [7:0] rxIrByte,
    // Transmit side to the serialisers
    input wire txReady,
    output reg txValid_r,
    output reg [7:0] txData_r,
    output reg txToIr_r,
    // Line flags and interrupt
    output reg dataReady_r,
    output reg holdingEmpty_r,
    output reg overrun_r,
    output reg irq_r
);

// ----------------------------------------------------------------
// Address phase decode
// ----------------------------------------------------------------

wire take;
wire isAlias;
wire isCtrl;
wire isStatus;
wire isIrqStat;
wire isMask;

assign take = hsel & htrans[1] & hready;
// Only the sixteen aligned words decode as aliases; a misaligned address
// falls through to the unmapped case, reads as zero and ignores writes.
assign isAlias = (haddr >= `ALIAS_FIRST_ADDR) &&
                 (haddr <= `ALIAS_LAST_ADDR) &&
                 (haddr[1:0] == 2'h0);
assign isCtrl = (haddr == `CTRL_ADDR);
assign isStatus = (haddr == `STATUS_ADDR);
assign isIrqStat = (haddr == `IRQ_STATUS_ADDR);
assign isMask = (haddr == `IRQ_MASK_ADDR);

// Reads are served at the address-phase edge so that hrdata_r is a flop
// throughout the data phase; the receive head is popped at that edge too.
wire rdTake;
wire rdAlias;
wire rdIrqStat;

assign rdTake = take & ~hwrite;
assign rdAlias = rdTake & isAlias;
assign rdIrqStat = rdTake & isIrqStat;

// ----------------------------------------------------------------
// Write target capture
// ----------------------------------------------------------------

// Write targets are held for the data phase, where hwdata stands.
// Capturing only the decode keeps haddr off the write path, at the cost
// of one cycle between a write and its effect.
reg wrAlias_r;
reg wrCtrl_r;
reg wrMask_r;

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        wrAlias_r <= 1'b0;
        wrCtrl_r <= 1'b0;
        wrMask_r <= 1'b0;
    end else begin
        wrAlias_r <= take & hwrite & isAlias;
        wrCtrl_r <= take & hwrite & isCtrl;
        wrMask_r <= take & hwrite & isMask;
    end
end

// ----------------------------------------------------------------
// Control and mask registers
// ----------------------------------------------------------------

reg [1:0] ctrl_r;
reg [`EVT_COUNT-1:0] mask_r;
wire fifoEn;
wire irMode;
wire modeFlush;

// Bit 0 turns both FIFOs on; bit 1 routes both directions to infrared.
assign fifoEn = ctrl_r[`CTRL_FIFO_EN_BIT];
assign irMode = ctrl_r[`CTRL_IR_MODE_BIT];
// Switching FIFO mode empties both paths so no stale byte crosses modes.
// Any byte still queued is lost, so software should drain both paths
// before it switches.
assign modeFlush = wrCtrl_r & (hwdata[`CTRL_FIFO_EN_BIT] != fifoEn);

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        ctrl_r <= `CTRL_RESET;
        mask_r <= `IRQ_MASK_RESET;
    end else begin
        if (wrCtrl_r) begin
            ctrl_r <= hwdata[1:0];
        end
        if (wrMask_r) begin
            mask_r <= hwdata[`EVT_COUNT-1:0];
        end
    end
end

// ----------------------------------------------------------------
// Receive path
// ----------------------------------------------------------------

wire [7:0] rxByte;
wire rxFifoReady;
wire rxFifoValid;
wire [7:0] rxFifoData;
reg [7:0] rxHold_r;
reg rxHoldValid_r;
wire rxOverrun;

assign rxByte = irMode ? rxIrByte : rxSerialByte;

// The receive FIFO fills only while FIFOs are on; with FIFOs off the
// single holding register below takes its place.
byte_fifo #(
    .WIDTH(8),
    .DEPTH(DEPTH),
    .AW(AW)
) rxFifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .flush(modeFlush),
    .pushValid(rxStrobe & fifoEn),
    .pushData(rxByte),
    .pushReady(rxFifoReady),
    .popValid(rxFifoValid),
    .popData(rxFifoData),
    .popReady(rdAlias & fifoEn)
);

// A full FIFO refuses the byte itself, so its contents stay intact.
// With FIFOs off a strobe in the cycle of a read is no overrun: the
// read takes the old byte as the new one lands.
assign rxOverrun = rxStrobe & (fifoEn ? ~rxFifoReady :
                   (rxHoldValid_r & ~rdAlias));

// A new byte always replaces the held one; the overrun pulse tells
// software that the earlier byte was lost.
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        rxHold_r <= 8'h00;
        rxHoldValid_r <= 1'b0;
    end else if (modeFlush) begin
        rxHoldValid_r <= 1'b0;
    end else if (!fifoEn) begin
        if (rxStrobe) begin
            rxHold_r <= rxByte;
            rxHoldValid_r <= 1'b1;
        end else if (rdAlias) begin
            rxHoldValid_r <= 1'b0;
        end
    end
end

wire dataReady;

// One flag follows whichever store is active in the current mode.
assign dataReady = fifoEn ? rxFifoValid : rxHoldValid_r;

// ----------------------------------------------------------------
// Transmit path
// ----------------------------------------------------------------

wire [7:0] wrByte;
wire txFifoReady;
wire txFifoValid;
wire [7:0] txFifoData;
reg [7:0] txHold_r;
reg txHoldFull_r;
wire txHave;
wire launch;
wire txDrop;

assign wrByte = hwdata[7:0];
assign txHave = fifoEn ? txFifoValid : txHoldFull_r;
// The serialiser sees one pulse per byte; the gap lets it drop ready.
assign launch = txReady & txHave & ~txValid_r;

byte_fifo #(
    .WIDTH(8),
    .DEPTH(DEPTH),
    .AW(AW)
) txFifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .flush(modeFlush),
    .pushValid(wrAlias_r & fifoEn),
    .pushData(wrByte),
    .pushReady(txFifoReady),
    .popValid(txFifoValid),
    .popData(txFifoData),
    .popReady(launch & fifoEn)
);

// Writes reach the store in the data phase, once hwdata is on the bus,
// and a write that finds the FIFO full only raises the drop event.
assign txDrop = wrAlias_r & fifoEn & ~txFifoReady;

// A write in the launch cycle keeps the new byte pending, so nothing
// is lost when software writes just as the serialiser takes a byte.
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        txHold_r <= 8'h00;
        txHoldFull_r <= 1'b0;
    end else if (modeFlush) begin
        txHoldFull_r <= 1'b0;
    end else if (!fifoEn) begin
        if (wrAlias_r) begin
            txHold_r <= wrByte;
            txHoldFull_r <= 1'b1;
        end else if (launch) begin
            txHoldFull_r <= 1'b0;
        end
    end
end

// txData_r keeps the last byte after the pulse, so a slow serialiser
// may take it at any time before the next launch.
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        txValid_r <= 1'b0;
        txData_r <= 8'h00;
        txToIr_r <= 1'b0;
    end else begin
        txValid_r <= launch;
        if (launch) begin
            txData_r <= fifoEn ? txFifoData : txHold_r;
            txToIr_r <= irMode;
        end
    end
end

wire holdingEmpty;

// Live here; the pin copy lags by one cycle.
assign holdingEmpty = ~txHave;

// ----------------------------------------------------------------
// Interrupt status
// ----------------------------------------------------------------

wire [`EVT_COUNT-1:0] events;
wire [`EVT_COUNT-1:0] irqStatus;
wire irqLevel;

assign events[`EVT_RX_DATA_BIT] = rxStrobe & ~rxOverrun;
assign events[`EVT_OVERRUN_BIT] = rxOverrun;
assign events[`EVT_TX_DROP_BIT] = txDrop;
// The registered flag resets to one, so reset itself raises no empty
// event; only a drain after a write does.
assign events[`EVT_HOLD_EMPTY_BIT] = holdingEmpty & ~holdingEmpty_r;

irq_status #(
    .N(`EVT_COUNT)
) irqUnit (
    .mclk(mclk),
    .reset_n(reset_n),
    .events(events),
    .readClear(rdIrqStat),
    .mask(mask_r),
    .status_r(irqStatus),
    .irq_r(irqLevel)
);

// ----------------------------------------------------------------
// Read data and flag outputs
// ----------------------------------------------------------------

// Unmapped addresses fall through to zero and are still answered OKAY.
reg [31:0] rdata_nxt;

always @* begin
    rdata_nxt = 32'h00000000;
    if (isAlias) begin
        // Upper bits stay zero; head is returned even when not ready.
        rdata_nxt[7:0] = fifoEn ? rxFifoData : rxHold_r;
    end else if (isCtrl) begin
        rdata_nxt[1:0] = ctrl_r;
    end else if (isStatus) begin
        rdata_nxt[`STATUS_DATA_READY_BIT] = dataReady;
        rdata_nxt[`STATUS_HOLD_EMPTY_BIT] = holdingEmpty;
    end else if (isIrqStat) begin
        rdata_nxt[`EVT_COUNT-1:0] = irqStatus;
    end else if (isMask) begin
        rdata_nxt[`EVT_COUNT-1:0] = mask_r;
    end
end

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        hrdata_r <= 32'h00000000;
        hreadyout_r <= 1'b1;
        hresp_r <= 1'b0;
        dataReady_r <= 1'b0;
        holdingEmpty_r <= 1'b1;
        overrun_r <= 1'b0;
        irq_r <= 1'b0;
    end else begin
        // No wait states: the slave never stretches a transfer, so ready
        // and the response stay constant after reset.
        hreadyout_r <= 1'b1;
        hresp_r <= 1'b0;
        if (rdTake) begin
            hrdata_r <= rdata_nxt;
        end
        dataReady_r <= dataReady;
        holdingEmpty_r <= holdingEmpty;
        overrun_r <= rxOverrun;
        // The pin is one cycle behind the interrupt unit's own flop.
        irq_r <= irqLevel;
    end
end

endmodule // uart_shadow_data_port

// [rtl/uart_shadow_regs.vh]
// Constants of the UART shadow data port: addresses, fields, resets, sizes.
// Assumes a 32-bit AHB-Lite address space, word-aligned registers.
//
// Contract
// - Alias of receive and transmit over sixteen words.
// - Read returns byte from serial or infrared input.
// - FIFOs off: unread byte overwritten, overrun flagged.
// - FIFOs on: read returns receive FIFO head.
// - Full receive FIFO: keep contents, drop, overrun.
// - Written byte goes to serial or infrared output.
// - FIFOs off: one write clears holding-empty.
// - FIFOs off: further writes overwrite pending byte.
// - FIFOs on: accept depth writes before full.
// - Write to full transmit FIFO is dropped.
`ifndef UART_SHADOW_REGS_VH
`define UART_SHADOW_REGS_VH

// Sixteen word aliases; index 13 is the one named in the register table.
`define ALIAS_FIRST_ADDR 32'h50001030
`define ALIAS_13_ADDR 32'h50001064
`define ALIAS_LAST_ADDR 32'h5000106c
`define ALIAS_RESET 16'h0000

`define CTRL_ADDR 32'h50001100
`define STATUS_ADDR 32'h50001104
`define IRQ_STATUS_ADDR 32'h50001108
`define IRQ_MASK_ADDR 32'h5000110c

`define CTRL_FIFO_EN_BIT 0
`define CTRL_IR_MODE_BIT 1
`define CTRL_RESET 2'h0

`define STATUS_DATA_READY_BIT 0
`define STATUS_HOLD_EMPTY_BIT 1

`define EVT_RX_DATA_BIT 0
`define EVT_OVERRUN_BIT 1
`define EVT_TX_DROP_BIT 2
`define EVT_HOLD_EMPTY_BIT 3
`define EVT_COUNT 4
`define IRQ_MASK_RESET 4'h0

`define FIFO_DEPTH 16
`define FIFO_ADDR_BITS 4

`endif

// [rtl/byte_fifo.v]
// Synchronous FIFO in flip-flops with valid/ready on both sides.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps

module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    input wire flush,
    // Fill side
    input wire pushValid,
    input wire [WIDTH-1:0] pushData,
    output wire pushReady,
    // Drain side
    output wire popValid,
    output wire [WIDTH-1:0] popData,
    input wire popReady
);

reg [WIDTH-1:0] mem_r [0:DEPTH-1];
reg [AW-1:0] wrPtr_r;
reg [AW-1:0] rdPtr_r;
reg [AW:0] count_r;
wire doPush;
wire doPop;
integer i;

assign pushReady = (count_r != DEPTH[AW:0]);
assign popValid = (count_r != {(AW+1){1'b0}});
assign popData = mem_r[rdPtr_r];
assign doPush = pushValid & pushReady;
assign doPop = popValid & popReady;

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        wrPtr_r <= {AW{1'b0}};
        rdPtr_r <= {AW{1'b0}};
        count_r <= {(AW+1){1'b0}};
        for (i = 0; i < DEPTH; i = i + 1) begin
            mem_r[i] <= {WIDTH{1'b0}};
        end
    end else if (flush) begin
        wrPtr_r <= {AW{1'b0}};
        rdPtr_r <= {AW{1'b0}};
        count_r <= {(AW+1){1'b0}};
    end else begin
        if (doPush) begin
            mem_r[wrPtr_r] <= pushData;
            wrPtr_r <= (wrPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                       wrPtr_r + 1'b1;
        end
        if (doPop) begin
            rdPtr_r <= (rdPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                       rdPtr_r + 1'b1;
        end
        if (doPush && !doPop) begin
            count_r <= count_r + 1'b1;
        end else if (doPop && !doPush) begin
            count_r <= count_r - 1'b1;
        end
    end
end

endmodule // byte_fifo

// [rtl/irq_status.v]
// Sticky event status with read-to-clear and a masked level interrupt.
// Assumes events are one-cycle pulses; a set in the clearing cycle wins.
`timescale 1ns/1ps

module irq_status #(
    parameter N = 4
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Events and software access
    input wire [N-1:0] events,
    input wire readClear,
    input wire [N-1:0] mask,
    // State
    output reg [N-1:0] status_r,
    output reg irq_r
);

wire [N-1:0] status_nxt;

assign status_nxt = (readClear ? {N{1'b0}} : status_r) | events;

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        status_r <= {N{1'b0}};
        irq_r <= 1'b0;
    end else begin
        status_r <= status_nxt;
        irq_r <= |(status_nxt & mask);
    end
end

endmodule // irq_status

// [verif/uart_shadow_data_port_checker.sv]
// Port-level assertions of the shadow data port.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`include "uart_shadow_regs.vh"
module uart_shadow_data_port_checker (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Bus
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata_r,
    input wire hreadyout_r,
    input wire hresp_r,
    // Line side
    input wire rxStrobe,
    input wire txReady,
    input wire txValid_r,
    input wire [7:0] txData_r,
    input wire dataReady_r,
    input wire holdingEmpty_r,
    input wire overrun_r
);
default clocking @(posedge mclk); endclocking
default disable iff (!reset_n);
wire rdAlias = hsel && htrans[1] && hready && !hwrite &&
    haddr >= `ALIAS_FIRST_ADDR && haddr <= `ALIAS_LAST_ADDR;
property p_okay; !hresp_r && hreadyout_r; endproperty
a_okay: assert property (p_okay)
    else $error("bus answer not okay");
property p_upper; rdAlias |=> hrdata_r[31:8] == 24'h000000; endproperty
a_upper: assert property (p_upper)
    else $error("upper read bits set");
property p_rxReady;
    (!hsel)[*2] ##0 rxStrobe ##1 !hsel |=> dataReady_r;
endproperty
a_rxReady: assert property (p_rxReady)
    else $error("no data ready after strobe");
property p_ovr; overrun_r |-> $past(rxStrobe); endproperty
a_ovr: assert property (p_ovr)
    else $error("overrun without byte");
property p_txPulse; txValid_r |=> !txValid_r; endproperty
a_txPulse: assert property (p_txPulse)
    else $error("launch pulse too long");
property p_txCause; $rose(txValid_r) |-> $past(txReady); endproperty
a_txCause: assert property (p_txCause)
    else $error("launch while not ready");
property p_txData; !txValid_r |-> $stable(txData_r); endproperty
a_txData: assert property (p_txData)
    else $error("tx byte moved");
property p_hold;
    $fell(holdingEmpty_r) |-> $past(hsel && htrans[1] && hwrite, 3);
endproperty
a_hold: assert property (p_hold)
    else $error("empty fell without write");
endmodule // uart_shadow_data_port_checker

// [verif/serial_far_end.sv]
// Far-end transceiver model: feeds received bytes, takes sent ones.
// Assumes the port's clock; the bench drives stall.
`timescale 1ns/1ps
module serial_far_end (
    // Clock and control
    input wire mclk,
    input wire stall,
    // Toward the port
    output logic rxStrobe,
    output logic [7:0] rxSerialByte,
    output logic [7:0] rxIrByte,
    output wire txReady,
    // From the port
    input wire txValid_r,
    input wire [7:0] txData_r,
    input wire txToIr_r
);
logic [7:0] got[$];
logic lastIr = 1'b0;
initial begin
    rxStrobe = 1'b0;
    rxSerialByte = 8'h00;
    rxIrByte = 8'h00;
end
assign txReady = !stall;
always @(posedge mclk) begin
    if (txValid_r === 1'b1) begin
        got.push_back(txData_r);
        lastIr <= txToIr_r;
    end
end
task automatic send(input logic [7:0] s, input logic [7:0] i);
    @(posedge mclk);
    rxStrobe <= 1'b1;
    rxSerialByte <= s;
    rxIrByte <= i;
    @(posedge mclk);
    // Released lines show a changed value, not the stale byte.
    rxStrobe <= 1'b0;
    rxSerialByte <= ~s;
    rxIrByte <= ~i;
endtask
endmodule // serial_far_end

// [verif/uart_shadow_data_port_tb.sv]
// Self-checking bench: row table, then hand tests.
// Assumes the far-end model and the checker are compiled first.
`timescale 1ns/1ps
`include "uart_shadow_regs.vh"
module uart_shadow_data_port_tb;
logic mclk, reset_n, hsel, hwrite, stall;
logic [1:0] htrans;
logic [31:0] haddr, hwdata, rd;
wire [31:0] hrdata_r;
wire hreadyout_r, hresp_r, rxStrobe, txReady, txValid_r, txToIr_r;
wire [7:0] rxSerialByte, rxIrByte, txData_r;
wire dataReady_r, holdingEmpty_r, overrun_r, irq_r;
int errTotal, checksDone, ovr;
typedef struct packed {logic [3:0] idx; logic ir; logic [7:0] s, i, t;} row_t;
row_t rows[4] = '{'{4'h0, 1'b0, 8'h5a, 8'ha5, 8'h3c},
    '{4'hd, 1'b1, 8'h11, 8'hee, 8'hc3},
    '{4'hf, 1'b0, 8'hff, 8'h00, 8'h81},
    '{4'h7, 1'b1, 8'h00, 8'h7e, 8'h00}};
uart_shadow_data_port #(.DEPTH(4), .AW(2)) dut (.mclk(mclk),
    .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_r),
    .hrdata_r(hrdata_r), .hreadyout_r(hreadyout_r), .hresp_r(hresp_r),
    .rxStrobe(rxStrobe), .rxSerialByte(rxSerialByte),
    .rxIrByte(rxIrByte), .txReady(txReady), .txValid_r(txValid_r),
    .txData_r(txData_r), .txToIr_r(txToIr_r), .dataReady_r(dataReady_r),
    .holdingEmpty_r(holdingEmpty_r), .overrun_r(overrun_r), .irq_r(irq_r));
serial_far_end far (.mclk(mclk), .stall(stall), .rxStrobe(rxStrobe),
    .rxSerialByte(rxSerialByte), .rxIrByte(rxIrByte), .txReady(txReady),
    .txValid_r(txValid_r), .txData_r(txData_r), .txToIr_r(txToIr_r));
task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    checksDone++;
    if (g !== e) begin
        errTotal++;
        $display("wrong value %s expected %h seen %h", n, e, g);
    end
endtask
task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout_r !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout_r !== 1'b1) @(posedge mclk);
    rd = hrdata_r;
endtask
task automatic summarize();
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
always @(posedge mclk) if (overrun_r === 1'b1) ovr++;
initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
end
initial begin
    #200000;
    errTotal++;
    summarize();
end
initial begin
    {reset_n, hsel, hwrite, stall, htrans, haddr, hwdata} = '0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    foreach (rows[k]) begin
        bus(1, `CTRL_ADDR, {30'h0, rows[k].ir, 1'b0});
        far.send(rows[k].s, rows[k].i);
        repeat (3) @(posedge mclk);
        cmp("ready", 1, dataReady_r);
        bus(0, `STATUS_ADDR, 0);
        cmp("status", 32'h3, rd);
        bus(0, `ALIAS_FIRST_ADDR + {rows[k].idx, 2'b00}, 0);
        cmp("rx", rows[k].ir ? rows[k].i : rows[k].s, rd);
        bus(1, `ALIAS_FIRST_ADDR + {rows[k].idx, 2'b00}, {24'hff, rows[k].t});
        repeat (4) @(posedge mclk);
        cmp("tx", rows[k].t, far.got.pop_front());
        cmp("tx ir", rows[k].ir, far.lastIr);
    end
    $display("test rows done");
    bus(0, `IRQ_STATUS_ADDR, 0);
    bus(1, `IRQ_MASK_ADDR, 0);
    ovr = 0;
    far.send(8'h12, 8'h12);
    far.send(8'h34, 8'h34);
    repeat (3) @(posedge mclk);
    cmp("overrun", 1, ovr);
    cmp("irq masked", 0, irq_r);
    bus(1, `IRQ_MASK_ADDR, 32'h2);
    // The new mask acts one edge late and the pin trails by two flops.
    repeat (3) @(posedge mclk);
    cmp("irq", 1, irq_r);
    bus(0, `IRQ_STATUS_ADDR, 0);
    cmp("irq status", 32'h3, rd);
    repeat (2) @(posedge mclk);
    cmp("irq cleared", 0, irq_r);
    bus(0, `ALIAS_13_ADDR, 0);
    cmp("overwritten", 32'h34, rd);
    $display("test overwrite done");
    bus(1, `CTRL_ADDR, 1);
    ovr = 0;
    for (int j = 0; j < 5; j++) far.send(8'h40 + j, 8'h00);
    repeat (3) @(posedge mclk);
    cmp("fifo overrun", 1, ovr);
    for (int j = 0; j < 4; j++) begin
        bus(0, `ALIAS_LAST_ADDR, 0);
        cmp("fifo head", 8'h40 + j, rd);
    end
    stall <= 1'b1;
    bus(0, `IRQ_STATUS_ADDR, 0);
    cmp("empty", 1, holdingEmpty_r);
    for (int j = 0; j < 5; j++) bus(1, `ALIAS_13_ADDR, 8'h60 + j);
    repeat (2) @(posedge mclk);
    bus(0, `IRQ_STATUS_ADDR, 0);
    cmp("drop flag", 1, rd[2]);
    stall <= 1'b0;
    repeat (16) @(posedge mclk);
    for (int j = 0; j < 4; j++)
        cmp("fifo tx", 8'h60 + j, far.got.pop_front());
    cmp("tx count", 0, far.got.size());
    $display("test fifo done");
    bus(1, `CTRL_ADDR, 0);
    stall <= 1'b1;
    bus(1, `ALIAS_13_ADDR, 8'ha1);
    repeat (2) @(posedge mclk);
    cmp("empty low", 0, holdingEmpty_r);
    bus(1, `ALIAS_13_ADDR, 8'hb2);
    stall <= 1'b0;
    repeat (6) @(posedge mclk);
    cmp("replaced", 8'hb2, far.got.pop_front());
    cmp("one sent", 0, far.got.size());
    $display("test holding done");
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    cmp("reset empty", 1, holdingEmpty_r);
    cmp("reset ready", 0, dataReady_r);
    reset_n <= 1'b1;
    bus(0, `ALIAS_13_ADDR, 0);
    cmp("alias reset", 32'h0, rd);
    bus(0, `IRQ_MASK_ADDR, 0);
    cmp("mask reset", 32'h0, rd);
    bus(0, `CTRL_ADDR, 0);
    cmp("ctrl reset", 32'h0, rd);
    bus(0, 32'h50001200, 0);
    cmp("unmapped", 32'h0, rd);
    $display("test reset done");
    summarize();
end
endmodule // uart_shadow_data_port_tb
bind uart_shadow_data_port uart_shadow_data_port_checker chk (
    .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata_r(hrdata_r), .hreadyout_r(hreadyout_r), .hresp_r(hresp_r),
    .rxStrobe(rxStrobe), .txReady(txReady), .txValid_r(txValid_r),
    .txData_r(txData_r), .dataReady_r(dataReady_r),
    .holdingEmpty_r(holdingEmpty_r), .overrun_r(overrun_r));
